// >>> pkg/otc_regs.svh
`ifndef OTC_REGS_SVH
`define OTC_REGS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define OTC_CLK_HZ              200000000
`define OTC_SEC_CYCLES          (`OTC_CLK_HZ / 1)
`define OTC_LINE_TIMEOUT_MS     100
`define OTC_LINE_TIMEOUT_CYCLES ((`OTC_CLK_HZ / 1000) * `OTC_LINE_TIMEOUT_MS)
`define OTC_START_HOLD_S        3
`define OTC_HOLD_ALARM_S        5
`define OTC_PULSE_S             30
// ----------------------------------------
// temperature and time limits
// ----------------------------------------
`define OTC_SET_MAX             500
`define OTC_OVER_MARGIN         50
`define OTC_REG_TOL             5
`define OTC_TIME_STEP_S         10
`define OTC_TIME_MAX_S          359940
// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define OTC_REG_CTRL            8'h00
`define OTC_REG_HOLD            8'h04
`define OTC_REG_SETPT           8'h08
`define OTC_REG_STATUS          8'h0C
`define OTC_REG_TEMP            8'h10
`define OTC_REG_TIMER           8'h14
`define OTC_CTRL_COOK           0
`define OTC_CTRL_HOLD           1
`define OTC_CTRL_PULSE          2
`define OTC_CTRL_HRMIN          3
`define OTC_CTRL_FCLR           4
`define OTC_SETPT_RST           10'h15E
`define OTC_HOLD_RST            10'h000
// ----------------------------------------
// synchronised pin positions
// ----------------------------------------
`define OTC_PIN_TUP             0
`define OTC_PIN_TDN             1
`define OTC_PIN_CUP             2
`define OTC_PIN_CDN             3
`define OTC_PIN_START           4
`define OTC_PIN_STIMER          5
`define OTC_PIN_CANCEL          6
`define OTC_PIN_LINE            7
`define OTC_PIN_SENSE           8
`define OTC_PIN_POPEN           9
`define OTC_PIN_PSHORT          10
`define OTC_PIN_N               11
`endif

// >>> pkg/otc_pkg.sv
`include "otc_regs.svh"
package otc_pkg;
  // timer sequence
  typedef enum logic [2:0] {
    TM_IDLE  = 3'b000,
    TM_ARMED = 3'b001,
    TM_RUN   = 3'b010,
    TM_ALARM = 3'b011,
    TM_HOLD  = 3'b100
  } otc_timer_type;

  // whole controller state
  typedef struct packed {
    logic [`OTC_PIN_N-1:0] sync1;
    logic [`OTC_PIN_N-1:0] sync2;
    logic [`OTC_PIN_N-1:0] sync3;
    logic [`OTC_PIN_N-1:0] stable;
    logic [`OTC_PIN_N-1:0] prevStable;
    logic [27:0]           secCnt;
    logic [24:0]           lineCnt;
    logic                  cookEn;
    logic                  holdEn;
    logic                  pulseEn;
    logic                  hrMinOnly;
    logic [9:0]            holdTemp;
    logic [9:0]            setpoint;
    logic [9:0]            tempMeas;
    logic                  reached;
    logic                  demand;
    logic                  heat;
    logic                  fan;
    logic                  alarm;
    logic [6:0]            faults;
    logic [2:0]            faultCode;
    otc_timer_type         tm;
    logic [18:0]           remain;
    logic [2:0]            alarmSecs;
    logic [4:0]            pulseSecs;
    logic                  fanPhase;
    logic [1:0]            startSecs;
    logic                  showActual;
    logic [1:0]            heatAge;
    logic [9:0]            dispTemp;
    logic [7:0]            dispHi;
    logic [7:0]            dispLo;
    logic                  apbAck;
    logic                  slvErr;
    logic [31:0]           rdata;
  } otc_state_type;
endpackage

// >>> logic/otc_controller.sv
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/100ps
`include "otc_regs.svh"
// Overview of operation
// - relay sense active while no cook cycle raises relay-stuck-on fault
// - measured temperature at or above 550 raises over-temperature fault
// - open probe input raises open-probe fault
// - shorted probe input raises shorted-probe fault
// - heat relay commanded but never sensed during cook raises relay-fails-on fault
// - no line-frequency edges within the timeout raise the line fault
// - checksum mismatch raises fault, outputs go off, then alarm sounds
// - below setpoint the heat relay is on and temperature digits blink
// - setpoint reached turns heat off and digits steady
// - any setpoint change restarts blinking until the new setpoint is reached
// - regulation keeps temperature within five degrees of setpoint
// - start key held three seconds shows measured temperature
// - temperature dial up raises setpoint, dial down lowers it
// - timer shows min:sec in first hour, hr:min above
// - entered time blinks until start-timer key starts countdown
// - preference bit forces hr:min display throughout
// - standard expiry sounds alarm until cancel-timer key
// - standard timer does not touch the heat relay
// - hold expiry: five second alarm, hold shown, fan off
// - hold swaps in hold temperature; once reached fan follows heat
// - cancel leaves hold; hold program stays enabled
// - pulse mode: fan 30 s open, 30 s closed, fixed
module otc_controller #(
  parameter int SEC_CYCLES  = `OTC_SEC_CYCLES,
  parameter int LINE_CYCLES = `OTC_LINE_TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // dials and keys (asynchronous pins)
  input  wire logic        tempDialUp,
  input  wire logic        tempDialDown,
  input  wire logic        timeDialUp,
  input  wire logic        timeDialDown,
  input  wire logic        startKey,
  input  wire logic        startTimerKey,
  input  wire logic        cancelTimerKey,
  // sensing pins
  input  wire logic        lineFreqPin,
  input  wire logic        heatRelaySense,
  input  wire logic        probeOpenPin,
  input  wire logic        probeShortPin,
  // resistive_temp_probe converter, same clock
  input  wire logic [9:0]  probeTemp,
  input  wire logic        probeValid,
  // nonvolatile checksum check, same clock
  input  wire logic [15:0] nvCalcSum,
  input  wire logic [15:0] nvStoredSum,
  input  wire logic        nvSumValid,
  // relays and alarm
  output logic             heatRelay,
  output logic             fanRelay,
  output logic             alarmOut,
  // display
  output logic [9:0]       dispTemp,
  output logic             dispTempBlink,
  output logic [7:0]       dispTimeHi,
  output logic [7:0]       dispTimeLo,
  output logic             dispTimeBlink,
  output logic             dispHold,
  output logic [2:0]       faultCode
);
  import otc_pkg::*;

  localparam logic [9:0]  SET_MAX    = 10'(`OTC_SET_MAX);
  localparam logic [10:0] OVER_LIMIT = 11'(`OTC_SET_MAX + `OTC_OVER_MARGIN);
  localparam logic [10:0] REG_TOL    = 11'(`OTC_REG_TOL);
  localparam logic [18:0] TIME_STEP  = 19'(`OTC_TIME_STEP_S);
  localparam logic [18:0] TIME_MAX   = 19'(`OTC_TIME_MAX_S);
  localparam logic [1:0]  START_S    = 2'(`OTC_START_HOLD_S);
  localparam logic [2:0]  HOLD_AL_S  = 3'(`OTC_HOLD_ALARM_S);
  localparam logic [4:0]  PULSE_LAST = 5'(`OTC_PULSE_S - 1);
  localparam logic [27:0] SEC_LAST   = 28'(SEC_CYCLES - 1);
  localparam logic [24:0] LINE_LAST  = 25'(LINE_CYCLES - 1);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // lowest numbered active fault wins the display
  function automatic logic [2:0] firstFault(input logic [6:0] f);
    logic [2:0] code;
    code = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (f[i]) begin
        code = 3'(i + 1);
      end
    end
    return code;
  endfunction

  // remaining seconds to two display fields
  function automatic logic [15:0] splitTime(input logic [18:0] s, input logic hrMin);
    logic [15:0] r;
    r = 16'h0000;
    if (!hrMin && s < 19'(3600)) begin
      r = {8'(s / 19'(60)), 8'(s % 19'(60))};
    end else begin
      r = {8'(s / 19'(3600)), 8'((s / 19'(60)) % 19'(60))};
    end
    return r;
  endfunction

  otc_state_type         st_ff;
  otc_state_type         nxt_st;
  logic [`OTC_PIN_N-1:0] pinsIn;
  logic [`OTC_PIN_N-1:0] edges;
  logic [6:0]            faultNow;
  logic [31:0]           regRead;
  logic                  regMapped;
  logic                  secTick;
  logic                  apbDone;
  logic                  wrEn;
  logic                  setChange;
  logic                  anyFault;
  logic                  lineEdge;

  assign pinsIn = {probeShortPin, probeOpenPin, heatRelaySense, lineFreqPin, cancelTimerKey,
                   startTimerKey, startKey, timeDialDown, timeDialUp, tempDialDown, tempDialUp};

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  always_comb begin
    regRead   = 32'h0000_0000;
    regMapped = 1'b1;
    case (paddr)
      `OTC_REG_CTRL:   regRead = {28'h0, st_ff.hrMinOnly, st_ff.pulseEn, st_ff.holdEn, st_ff.cookEn};
      `OTC_REG_HOLD:   regRead = {22'h0, st_ff.holdTemp};
      `OTC_REG_SETPT:  regRead = {22'h0, st_ff.setpoint};
      `OTC_REG_STATUS: regRead = {19'h0, st_ff.tm, st_ff.alarm, st_ff.fan, st_ff.heat, st_ff.faults};
      `OTC_REG_TEMP:   regRead = {22'h0, st_ff.tempMeas};
      `OTC_REG_TIMER:  regRead = {13'h0, st_ff.remain};
      default:         regMapped = 1'b0;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st    = st_ff;
    setChange = 1'b0;
    // pins: three stages, a change counts once stages two and three agree
    nxt_st.sync1 = pinsIn;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    for (int i = 0; i < `OTC_PIN_N; i++) begin
      if (st_ff.sync2[i] == st_ff.sync3[i]) begin
        nxt_st.stable[i] = st_ff.sync3[i];
      end
    end
    nxt_st.prevStable = st_ff.stable;
    edges    = st_ff.stable & ~st_ff.prevStable;
    lineEdge = st_ff.stable[`OTC_PIN_LINE] ^ st_ff.prevStable[`OTC_PIN_LINE];
    anyFault = |st_ff.faults;

    // one second enable pulse
    secTick       = (st_ff.secCnt == SEC_LAST);
    nxt_st.secCnt = secTick ? 28'h0 : 28'(st_ff.secCnt + 28'h1);

    // apb: one wait state, read data captured in the first access cycle
    nxt_st.apbAck = psel & penable & ~st_ff.apbAck;
    apbDone       = psel & penable & st_ff.apbAck;
    wrEn          = apbDone & pwrite & regMapped;
    if (psel && penable && !st_ff.apbAck) begin
      nxt_st.rdata  = pwrite ? 32'h0000_0000 : regRead;
      nxt_st.slvErr = ~regMapped;
    end
    if (wrEn && paddr == `OTC_REG_CTRL) begin
      nxt_st.cookEn    = pwdata[`OTC_CTRL_COOK];
      nxt_st.holdEn    = pwdata[`OTC_CTRL_HOLD];   // stays until software removes it
      nxt_st.pulseEn   = pwdata[`OTC_CTRL_PULSE];
      nxt_st.hrMinOnly = pwdata[`OTC_CTRL_HRMIN];
    end
    if (wrEn && paddr == `OTC_REG_HOLD) begin
      nxt_st.holdTemp = (pwdata[9:0] > SET_MAX) ? SET_MAX : pwdata[9:0];
    end

    // setpoint from register or dial, clamped to the allowed range
    if (wrEn && paddr == `OTC_REG_SETPT) begin
      nxt_st.setpoint = (pwdata[9:0] > SET_MAX) ? SET_MAX : pwdata[9:0];
      setChange       = 1'b1;
    end else if (edges[`OTC_PIN_TUP] && st_ff.setpoint < SET_MAX) begin
      nxt_st.setpoint = 10'(st_ff.setpoint + 10'h1);
      setChange       = 1'b1;
    end else if (edges[`OTC_PIN_TDN] && st_ff.setpoint != 10'h000) begin
      nxt_st.setpoint = 10'(st_ff.setpoint - 10'h1);
      setChange       = 1'b1;
    end
    if (probeValid) begin
      nxt_st.tempMeas = probeTemp;
    end

    // timer sequence
    case (st_ff.tm)
      TM_IDLE, TM_ARMED: begin
        if (edges[`OTC_PIN_CUP]) begin
          nxt_st.remain = (st_ff.remain > TIME_MAX - TIME_STEP) ? TIME_MAX : 19'(st_ff.remain + TIME_STEP);
          nxt_st.tm     = TM_ARMED;
        end else if (edges[`OTC_PIN_CDN]) begin
          nxt_st.remain = (st_ff.remain > TIME_STEP) ? 19'(st_ff.remain - TIME_STEP) : 19'h0;
          nxt_st.tm     = TM_ARMED;
        end else if (st_ff.tm == TM_ARMED && edges[`OTC_PIN_STIMER] && st_ff.remain != 19'h0) begin
          nxt_st.tm = TM_RUN;  // blinking ends, countdown starts
        end
      end
      TM_RUN: begin
        if (edges[`OTC_PIN_CANCEL]) begin
          nxt_st.tm     = TM_IDLE;
          nxt_st.remain = 19'h0;
        end else if (secTick) begin
          nxt_st.remain = 19'(st_ff.remain - 19'h1);
          if (st_ff.remain == 19'h1) begin
            if (st_ff.holdEn) begin
              nxt_st.tm        = TM_HOLD;
              nxt_st.alarmSecs = HOLD_AL_S;
              nxt_st.setpoint  = st_ff.holdTemp;
              setChange        = 1'b1;
            end else begin
              nxt_st.tm = TM_ALARM;
            end
          end
        end
      end
      TM_ALARM: begin
        if (edges[`OTC_PIN_CANCEL]) begin
          nxt_st.tm = TM_IDLE;
        end
      end
      TM_HOLD: begin
        if (secTick && st_ff.alarmSecs != 3'h0) begin
          nxt_st.alarmSecs = 3'(st_ff.alarmSecs - 3'h1);
        end
        if (edges[`OTC_PIN_CANCEL]) begin
          nxt_st.tm        = TM_IDLE;
          nxt_st.alarmSecs = 3'h0;
        end
      end
      default: begin
        nxt_st.tm = TM_IDLE;
      end
    endcase

    // reached flag drives blinking; a new setpoint restarts it
    if (setChange) begin
      nxt_st.reached = 1'b0;
    end else if (st_ff.tempMeas >= st_ff.setpoint) begin
      nxt_st.reached = 1'b1;
    end
    // heat demand: straight to setpoint first, then a band below it
    if (st_ff.tempMeas >= st_ff.setpoint) begin
      nxt_st.demand = 1'b0;
    end else if (!st_ff.reached || 11'(st_ff.tempMeas) + REG_TOL < 11'(st_ff.setpoint)) begin
      nxt_st.demand = 1'b1;
    end

    // age of the heat command, used to judge the relay sense
    if (!st_ff.heat) begin
      nxt_st.heatAge = 2'h0;
    end else if (secTick && st_ff.heatAge != 2'h3) begin
      nxt_st.heatAge = 2'(st_ff.heatAge + 2'h1);
    end
    // line watchdog restarts on every line edge
    if (lineEdge) begin
      nxt_st.lineCnt = 25'h0;
    end else if (st_ff.lineCnt != LINE_LAST) begin
      nxt_st.lineCnt = 25'(st_ff.lineCnt + 25'h1);
    end

    // fault detection; a new fault wins over a clear in the same cycle
    faultNow[0] = st_ff.stable[`OTC_PIN_SENSE] & ~st_ff.cookEn;
    faultNow[1] = 11'(st_ff.tempMeas) >= OVER_LIMIT;
    faultNow[2] = st_ff.stable[`OTC_PIN_POPEN];
    faultNow[3] = st_ff.stable[`OTC_PIN_PSHORT];
    faultNow[4] = st_ff.cookEn & st_ff.heat & ~st_ff.stable[`OTC_PIN_SENSE] & (&st_ff.heatAge);
    faultNow[5] = (st_ff.lineCnt == LINE_LAST);
    faultNow[6] = nvSumValid & (nvCalcSum != nvStoredSum);
    if (wrEn && paddr == `OTC_REG_CTRL && pwdata[`OTC_CTRL_FCLR]) begin
      nxt_st.faults = faultNow;
    end else begin
      nxt_st.faults = st_ff.faults | faultNow;
    end
    nxt_st.faultCode = firstFault(st_ff.faults);

    // pulse mode phase, a fixed thirty second half period
    if (!st_ff.pulseEn || !st_ff.cookEn) begin
      nxt_st.pulseSecs = 5'h0;
      nxt_st.fanPhase  = 1'b0;
    end else if (secTick) begin
      if (st_ff.pulseSecs == PULSE_LAST) begin
        nxt_st.pulseSecs = 5'h0;
        nxt_st.fanPhase  = ~st_ff.fanPhase;
      end else begin
        nxt_st.pulseSecs = 5'(st_ff.pulseSecs + 5'h1);
      end
    end

    // relays: timer state never enters the heat term in standard mode
    nxt_st.heat = st_ff.cookEn & st_ff.demand & ~anyFault;
    if (!st_ff.cookEn || anyFault) begin
      nxt_st.fan = 1'b0;
    end else if (st_ff.tm == TM_HOLD) begin
      nxt_st.fan = st_ff.reached & st_ff.demand;  // off at entry, then with heat
    end else if (st_ff.pulseEn) begin
      nxt_st.fan = ~st_ff.fanPhase;
    end else begin
      nxt_st.fan = 1'b1;
    end
    // checksum alarm waits until both relays are seen off
    nxt_st.alarm = (st_ff.faults[6] & ~st_ff.heat & ~st_ff.fan)
                 | (nxt_st.tm == TM_ALARM)
                 | (nxt_st.tm == TM_HOLD && nxt_st.alarmSecs != 3'h0);

    // start key held for three seconds switches to measured temperature
    if (!st_ff.stable[`OTC_PIN_START]) begin
      nxt_st.startSecs  = 2'h0;
      nxt_st.showActual = 1'b0;
    end else begin
      if (secTick && st_ff.startSecs != START_S) begin
        nxt_st.startSecs = 2'(st_ff.startSecs + 2'h1);
      end
      if (st_ff.startSecs == START_S) begin
        nxt_st.showActual = 1'b1;
      end
    end

    // display registers; temperature digits blank while a fault code is shown, timer digits stay
    if (anyFault) begin
      nxt_st.dispTemp = 10'h000;
    end else begin
      nxt_st.dispTemp = st_ff.showActual ? st_ff.tempMeas : st_ff.setpoint;
    end
    {nxt_st.dispHi, nxt_st.dispLo} = splitTime(st_ff.remain, st_ff.hrMinOnly);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff          <= '0;
      st_ff.setpoint <= `OTC_SETPT_RST;
      st_ff.holdTemp <= `OTC_HOLD_RST;
      st_ff.tm       <= TM_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from state
  assign pready        = st_ff.apbAck;
  assign prdata        = st_ff.rdata;
  assign pslverr       = st_ff.apbAck & st_ff.slvErr;
  assign heatRelay     = st_ff.heat;
  assign fanRelay      = st_ff.fan;
  assign alarmOut      = st_ff.alarm;
  assign dispTemp      = st_ff.dispTemp;
  assign dispTempBlink = ~st_ff.reached;
  assign dispTimeHi    = st_ff.dispHi;
  assign dispTimeLo    = st_ff.dispLo;
  assign dispTimeBlink = (st_ff.tm == TM_ARMED);
  assign dispHold      = (st_ff.tm == TM_HOLD);
  assign faultCode     = st_ff.faultCode;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  fault_heat_off_a: assert property ((|st_ff.faults) |=> !heatRelay)
    else $error("heat relay on while a fault is latched");
  over_temp_a: assert property (st_ff.tempMeas >= 10'(`OTC_SET_MAX + `OTC_OVER_MARGIN) |=> st_ff.faults[1])
    else $error("over temperature not flagged");
  stuck_on_a: assert property (st_ff.stable[`OTC_PIN_SENSE] && !st_ff.cookEn |=> st_ff.faults[0])
    else $error("relay stuck on not flagged");
  nv_order_a: assert property ($rose(alarmOut) && st_ff.faults[6] && st_ff.tm != TM_ALARM && st_ff.tm != TM_HOLD
                               |-> !$past(heatRelay) && !$past(fanRelay))
    else $error("checksum alarm before outputs off");
  heat_demand_a: assert property (st_ff.cookEn && st_ff.demand && !(|st_ff.faults) |=> heatRelay)
    else $error("heat demand not driving relay");
  change_blink_a: assert property (setChange |=> dispTempBlink)
    else $error("setpoint change did not restart blinking");
  hold_entry_a: assert property ($rose(dispHold) |-> alarmOut ##1 !fanRelay)
    else $error("hold entry without alarm or with fan on");
  pulse_period_a: assert property ($changed(st_ff.fanPhase) && $past(st_ff.pulseEn) && $past(st_ff.cookEn)
                                   |-> st_ff.pulseSecs == 5'h00 && $past(st_ff.pulseSecs) == 5'h1D)
    else $error("pulse phase length wrong");
  start_three_a: assert property ($rose(st_ff.showActual) |-> $past(st_ff.startSecs) == 2'd3)
    else $error("actual temperature shown too early");
  expiry_alarm_a: assert property (st_ff.tm == TM_ALARM && !edges[`OTC_PIN_CANCEL] |=> alarmOut)
    else $error("expiry alarm dropped before cancel");
endmodule

// >>> test/otc_oven_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// oven stand-in: probe, contact sense, mains
// ----------------------------------------
module otc_oven_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // bench controls
  input  wire logic [9:0] tempIn,
  input  wire logic       stuckOn,
  input  wire logic       senseFail,
  input  wire logic       lineStop,
  // controller side
  input  wire logic       heatRelay,
  output logic [9:0]      probeTemp,
  output logic            probeValid,
  output logic            heatRelaySense,
  output logic            lineFreqPin
);
  logic [4:0] divCnt;
  // contacts lag the coil a cycle, so a cook-off write with heat on looks stuck
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      divCnt         <= 5'h00;
      lineFreqPin    <= 1'b0;
      heatRelaySense <= 1'b0;
      probeTemp      <= 10'h000;
      probeValid     <= 1'b0;
    end else begin
      divCnt         <= divCnt + 5'h01;
      lineFreqPin    <= (divCnt == 5'h1F && !lineStop) ? ~lineFreqPin : lineFreqPin;
      heatRelaySense <= (heatRelay && !senseFail) || stuckOn;
      probeTemp      <= tempIn;
      probeValid     <= 1'b1;
    end
  end
endmodule

// >>> test/tb.sv
`timescale 1ns/100ps
`include "otc_regs.svh"
module tb;
  localparam int SEC = 20;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, heatRelay, fanRelay, alarmOut, tBlink, mBlink, dispHold;
  logic [6:0]  keys = 7'h00, cause = 7'h00;
  logic [9:0]  tempIn = 10'd340, probeTemp, dispTemp;
  logic        probeValid, sense, linePin;
  logic [2:0]  faultCode;
  logic [7:0]  tHi, tLo;
  int          errors = 0;
  int          tests_run = 0;
  // ----------------------------------------
  // clock, design and oven stand-in
  // ----------------------------------------
  always #2.5 clock = ~clock;
  otc_controller #(.SEC_CYCLES(SEC), .LINE_CYCLES(200)) uut (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .tempDialUp(keys[0]), .tempDialDown(keys[1]), .timeDialUp(keys[2]),
    .timeDialDown(keys[3]), .startKey(keys[4]), .startTimerKey(keys[5]), .cancelTimerKey(keys[6]),
    .lineFreqPin(linePin), .heatRelaySense(sense), .probeOpenPin(cause[2]), .probeShortPin(cause[3]),
    .probeTemp(probeTemp), .probeValid(probeValid), .nvCalcSum(16'h5A5A), .nvStoredSum({15'h2D2D, cause[6]}),
    .nvSumValid(1'b1), .heatRelay(heatRelay), .fanRelay(fanRelay), .alarmOut(alarmOut), .dispTemp(dispTemp),
    .dispTempBlink(tBlink), .dispTimeHi(tHi), .dispTimeLo(tLo), .dispTimeBlink(mBlink), .dispHold(dispHold),
    .faultCode(faultCode));
  otc_oven_model oven (.clock(clock), .nrst(nrst), .tempIn(cause[1] ? 10'd550 : tempIn), .stuckOn(cause[0]),
    .senseFail(cause[4]), .lineStop(cause[5]), .heatRelay(heatRelay), .probeTemp(probeTemp),
    .probeValid(probeValid), .heatRelaySense(sense), .lineFreqPin(linePin));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock iff pready === 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // pins are filtered, so hold each press well past the sync depth
  task automatic press(input int k);
    keys[k] <= 1'b1;
    repeat (8) @(posedge clock);
    keys[k] <= 1'b0;
    repeat (10) @(posedge clock);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_dial;
    apb(1'b0, `OTC_REG_SETPT, 32'h0);
    chk("setpoint reset", rd, 32'h0000015E);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    press(0);
    apb(1'b0, `OTC_REG_SETPT, 32'h0);
    chk("dial up", rd, 32'h0000015F);
    press(1);
    press(1);
    apb(1'b0, `OTC_REG_SETPT, 32'h0);
    chk("dial down", rd, 32'h0000015D);
    $display("test dial done");
  endtask
  task automatic t_heat;
    tempIn <= 10'd300;
    apb(1'b1, `OTC_REG_SETPT, 32'd350);
    apb(1'b1, `OTC_REG_CTRL, 32'h1);
    repeat (10) @(posedge clock);
    chk("heat below", heatRelay, 1);
    chk("blink below", tBlink, 1);
    keys[4] <= 1'b1;
    repeat (4*SEC) @(posedge clock);
    chk("actual shown", dispTemp, 300);
    keys[4] <= 1'b0;
    tempIn <= 10'd350;
    repeat (10) @(posedge clock);
    chk("heat reached", heatRelay, 0);
    chk("steady reached", tBlink, 0);
    apb(1'b1, `OTC_REG_SETPT, 32'd360);
    repeat (10) @(posedge clock);
    chk("blink on change", tBlink, 1);
    chk("heat 10 under", heatRelay, 1);
    tempIn <= 10'd360;
    repeat (10) @(posedge clock);
    chk("steady again", tBlink, 0);
    $display("test heat done");
  endtask
  task automatic t_timer(input logic hold);
    int n;
    apb(1'b1, `OTC_REG_HOLD, 32'd300);
    apb(1'b1, `OTC_REG_CTRL, {28'h0, hold, 1'b0, hold, 1'b1});
    press(2);
    chk("armed blink", mBlink, 1);
    chk("time digits", {tHi, tLo}, hold ? 16'h0000 : 16'h000A);
    repeat (3*SEC) @(posedge clock);
    apb(1'b0, `OTC_REG_TIMER, 32'h0);
    chk("armed holds", rd, 32'd10);
    press(5);
    chk("started", mBlink, 0);
    tempIn <= 10'd340;
    for (n = 0; n < 15*SEC && alarmOut !== 1'b1; n++) @(posedge clock);
    chk("expiry alarm", alarmOut, 1);
    if (hold) begin
      repeat (3) @(posedge clock);
      chk("hold shown", dispHold, 1);
      chk("fan off", fanRelay, 0);
      apb(1'b0, `OTC_REG_SETPT, 32'h0);
      chk("hold setpoint", rd, 32'd300);
      repeat (6*SEC) @(posedge clock);
      chk("alarm ended", alarmOut, 0);
      press(6);
      apb(1'b0, `OTC_REG_CTRL, 32'h0);
      chk("hold kept", {dispHold, rd[1]}, 2'b01);
    end else begin
      chk("heat ignores timer", heatRelay, 1);
      repeat (6*SEC) @(posedge clock);
      chk("alarm stays", alarmOut, 1);
      press(6);
      chk("alarm cancelled", alarmOut, 0);
    end
    $display("test timer done");
  endtask
  // toggle lands on the thirtieth second tick, so 28 s is safely before it
  task automatic t_pulse;
    apb(1'b1, `OTC_REG_CTRL, 32'h5);
    repeat (28*SEC) @(posedge clock);
    chk("pulse fan on", fanRelay, 1);
    repeat (3*SEC) @(posedge clock);
    chk("pulse fan off", fanRelay, 0);
    $display("test pulse done");
  endtask
  // code 1 runs with cook switched off while heat is still on, the rest with heat demanded
  task automatic t_fault(input int code);
    int n;
    apb(1'b1, `OTC_REG_SETPT, 32'd500);
    apb(1'b1, `OTC_REG_CTRL, (code == 1) ? 32'h0 : 32'h1);
    cause <= 7'h01 << (code - 1);
    for (n = 0; n < 600 && faultCode === 3'h0; n++) @(posedge clock);
    repeat (3) @(posedge clock);
    chk("fault code", faultCode, code);
    chk("fault heat off", {heatRelay, dispTemp}, 0);
    if (code == 7) chk("checksum outputs", {heatRelay, fanRelay, alarmOut}, 3'b001);
    cause <= 7'h00;
    // mains pin resumes only on the model's 32-cycle beat; the watchdog needs an edge first
    repeat (40) @(posedge clock);
    apb(1'b1, `OTC_REG_CTRL, (code == 1) ? 32'h10 : 32'h11);
    repeat (10) @(posedge clock);
    chk("fault cleared", faultCode, 0);
    $display("test fault %0d done", code);
  endtask
  // ----------------------------------------
  // sequence, watchdog and verdict
  // ----------------------------------------
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    repeat (6) @(posedge clock);
    t_dial;
    t_heat;
    t_timer(1'b0);
    t_timer(1'b1);
    t_pulse;
    for (int c = 1; c < 8; c++) t_fault(c);
    final_report;
  end
  // whole run needs about 2500 cycles; this cuts a hang well beyond that
  initial begin
    #100000;
    errors++;
    final_report;
  end
endmodule
